// file: rtl/canbt_bit_timer.v
/*
 Edge locked bit timer for a CAN node: bit segment sequencing, sample
 point, hard sync and resync, resolved bit strobe, and a small register
 port for the timing fields.
 Assumes receive line and control inputs synchronous to sys_clk, and a
 protocol engine that reports bus idle and own transmission.
*/
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`include "canbt_defines.vh"

module canbt_bit_timer #(
   parameter PRESC_W = 6,
   parameter ADDR_W = 3,
   parameter LEN_W = 5
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Register port
   input wire [ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   // Mode and protocol engine status
   input wire config_mode,
   input wire bus_idle,
   input wire transmitting,
   // Bus receive line
   input wire can_receive_input,
   // Bit results
   output reg bit_value,
   output reg bit_strobe,
   output reg sample_strobe,
   output reg sync_event
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // A three-bit length field encodes one more quantum than its value
   function [LEN_W-1:0] field_len;
      input [2:0] field;
      begin
         field_len = {2'h0, field} + 5'h01;
      end
   endfunction

   // Larger of two lengths
   function [LEN_W-1:0] max_len;
      input [LEN_W-1:0] a;
      input [LEN_W-1:0] b;
      begin
         max_len = (a > b) ? a : b;
      end
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg [7:0] timing0;
   reg [7:0] timing1;
   reg [2:0] timing2;
   reg [1:0] seg_state;
   reg [LEN_W-1:0] seg_cnt;
   reg [LEN_W-1:0] ph1_ext;
   reg [LEN_W-1:0] ph2_short;
   reg sync_done;
   reg rx_prev;
   reg sampled_bit;
   reg [1:0] ipt_cnt;
   reg [1:0] next_state;
   reg [LEN_W-1:0] next_cnt;
   reg [LEN_W-1:0] next_ext;
   reg [LEN_W-1:0] next_short;
   reg next_sync_done;
   reg restart;
   reg take_sample;
   reg adjust;
   reg [LEN_W-1:0] ph1_end;
   reg [LEN_W-1:0] ph2_end;
   reg [LEN_W-1:0] pos_err;
   reg [LEN_W-1:0] neg_err;
   wire half_tick;
   wire tq_tick;
   wire voted_bit;
   wire fall_edge;
   wire [LEN_W-1:0] prop_len;
   wire [LEN_W-1:0] ph1_len;
   wire [LEN_W-1:0] ps2_len;
   wire [LEN_W-1:0] own_ph2_len;
   wire [LEN_W-1:0] jump_len;
   wire triple_sample_select;
   wire phase_two_source_select;

   // ----------------------------------------
   // Timing fields decoded
   // ----------------------------------------
   assign prop_len = field_len(timing1[`CANBT_PROP_MSB:`CANBT_PROP_LSB]);
   assign ph1_len = field_len(timing1[`CANBT_PH1_MSB:`CANBT_PH1_LSB]);
   assign jump_len = field_len({1'b0, timing0[`CANBT_JUMP_MSB:`CANBT_JUMP_LSB]});
   assign triple_sample_select = timing1[`CANBT_TRIPLE_BIT];
   assign phase_two_source_select = timing1[`CANBT_PH2SRC_BIT];
   // Own field clamped to the processing delay so the bit resolves in time
   assign own_ph2_len = max_len(field_len(timing2), `CANBT_IPT_TQ_LEN);
   assign ps2_len = phase_two_source_select ? own_ph2_len :
      max_len(ph1_len, `CANBT_IPT_TQ_LEN);

   // Only a recessive to dominant step is a candidate edge
   assign fall_edge = rx_prev && !can_receive_input;

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   canbt_quantum_prescaler #(
      .PRESC_W(PRESC_W)
   ) u_prescaler (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .quantum_prescaler(timing0[`CANBT_PRESC_MSB:`CANBT_PRESC_LSB]),
      .restart(restart),
      .half_tick(half_tick),
      .tq_tick(tq_tick)
   );

   canbt_sample_voter u_voter (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .half_tick(half_tick),
      .rx_level(can_receive_input),
      .triple_sample_select(triple_sample_select),
      .voted_bit(voted_bit)
   );

   // ----------------------------------------
   // Synchronization and segment sequencing
   // ----------------------------------------
   // Sync actions first, then the quantum step; a restart wins over a step
   always @*
   begin
      next_state = seg_state;
      next_cnt = seg_cnt;
      next_ext = ph1_ext;
      next_short = ph2_short;
      next_sync_done = sync_done;
      restart = 1'b0;
      take_sample = 1'b0;
      adjust = 1'b0;
      ph1_end = ph1_len + ph1_ext;
      ph2_end = ps2_len - ph2_short;
      // Positive error: quanta passed since the sync segment
      if (seg_state == `CANBT_ST_PROP)
         pos_err = seg_cnt + `CANBT_SYNC_TQ;
      else
         pos_err = seg_cnt + `CANBT_SYNC_TQ + prop_len;
      // Negative error: quanta left before the next sync segment
      neg_err = ph2_end - seg_cnt;
      // One sync per bit, and only if the last sample was recessive
      if (fall_edge && sampled_bit && !sync_done)
      begin
         if (bus_idle)
            restart = 1'b1;
         else
         begin
            case (seg_state)
               `CANBT_ST_SYNC:
                  restart = 1'b1;
               `CANBT_ST_PROP, `CANBT_ST_PH1:
               begin
                  // Own transmission: positive errors are dropped
                  if (!transmitting)
                  begin
                     if (pos_err <= jump_len)
                        restart = 1'b1;
                     else
                     begin
                        adjust = 1'b1;
                        next_ext = jump_len;
                        ph1_end = ph1_len + jump_len;
                     end
                  end
               end
               `CANBT_ST_PH2:
               begin
                  if (neg_err <= jump_len)
                     restart = 1'b1;
                  else
                  begin
                     adjust = 1'b1;
                     next_short = jump_len;
                     ph2_end = ps2_len - jump_len;
                  end
               end
               default:
                  restart = 1'b0;
            endcase
         end
      end
      if (adjust)
         next_sync_done = 1'b1;
      if (restart)
      begin
         // Edge now lies in the sync segment of the restarted bit
         next_state = `CANBT_ST_SYNC;
         next_cnt = {LEN_W{1'b0}};
         next_ext = {LEN_W{1'b0}};
         next_short = {LEN_W{1'b0}};
         next_sync_done = 1'b1;
      end
      else if (tq_tick)
      begin
         case (seg_state)
            `CANBT_ST_SYNC:
            begin
               // Sync segment is exactly one quantum
               next_state = `CANBT_ST_PROP;
               next_cnt = {LEN_W{1'b0}};
            end
            `CANBT_ST_PROP:
            begin
               if (seg_cnt >= prop_len - 5'h01)
               begin
                  next_state = `CANBT_ST_PH1;
                  next_cnt = {LEN_W{1'b0}};
               end
               else
                  next_cnt = seg_cnt + 5'h01;
            end
            `CANBT_ST_PH1:
            begin
               if (seg_cnt >= ph1_end - 5'h01)
               begin
                  next_state = `CANBT_ST_PH2;
                  next_cnt = {LEN_W{1'b0}};
                  take_sample = 1'b1;
               end
               else
                  next_cnt = seg_cnt + 5'h01;
            end
            `CANBT_ST_PH2:
            begin
               if (seg_cnt >= ph2_end - 5'h01)
               begin
                  // New bit: adjustments and the one-sync lock expire
                  next_state = `CANBT_ST_SYNC;
                  next_cnt = {LEN_W{1'b0}};
                  next_ext = {LEN_W{1'b0}};
                  next_short = {LEN_W{1'b0}};
                  next_sync_done = 1'b0;
               end
               else
                  next_cnt = seg_cnt + 5'h01;
            end
            default:
            begin
               next_state = `CANBT_ST_SYNC;
               next_cnt = {LEN_W{1'b0}};
            end
         endcase
      end
   end

   // ----------------------------------------
   // Timing state registers
   // ----------------------------------------
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         seg_state <= `CANBT_ST_SYNC;
         seg_cnt <= {LEN_W{1'b0}};
         ph1_ext <= {LEN_W{1'b0}};
         ph2_short <= {LEN_W{1'b0}};
         sync_done <= 1'b0;
         rx_prev <= 1'b1;
         sync_event <= 1'b0;
      end
      else
      begin
         seg_state <= next_state;
         seg_cnt <= next_cnt;
         ph1_ext <= next_ext;
         ph2_short <= next_short;
         sync_done <= next_sync_done;
         rx_prev <= can_receive_input;
         sync_event <= restart | adjust;
      end
   end

   // ----------------------------------------
   // Sample point and processing delay
   // ----------------------------------------
   // Latched sample also gates edge use in the next bit; strobe after two quanta
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sampled_bit <= 1'b1;
         sample_strobe <= 1'b0;
         bit_value <= 1'b1;
         bit_strobe <= 1'b0;
         ipt_cnt <= 2'h0;
      end
      else
      begin
         sample_strobe <= take_sample;
         bit_strobe <= 1'b0;
         if (take_sample)
         begin
            sampled_bit <= voted_bit;
            ipt_cnt <= `CANBT_IPT_TQ;
         end
         else if (tq_tick && ipt_cnt != 2'h0)
         begin
            ipt_cnt <= ipt_cnt - 2'h1;
            if (ipt_cnt == 2'h1)
            begin
               bit_value <= sampled_bit;
               bit_strobe <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   // Writes outside configuration mode are dropped to keep a live bit stable
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         timing0 <= `CANBT_RST_TIMING0;
         timing1 <= `CANBT_RST_TIMING1;
         timing2 <= `CANBT_RST_TIMING2;
      end
      else if (reg_write && config_mode)
      begin
         case (reg_addr)
            `CANBT_ADDR_TIMING0: timing0 <= reg_wdata;
            `CANBT_ADDR_TIMING1: timing1 <= reg_wdata;
            `CANBT_ADDR_TIMING2: timing2 <= reg_wdata[`CANBT_PH2_MSB:`CANBT_PH2_LSB];
            default: timing0 <= timing0;
         endcase
      end
   end

   // Read data stands for exactly the cycle after the strobe
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else if (reg_read)
      begin
         case (reg_addr)
            `CANBT_ADDR_TIMING0: reg_rdata <= timing0;
            `CANBT_ADDR_TIMING1: reg_rdata <= timing1;
            `CANBT_ADDR_TIMING2: reg_rdata <= {5'h00, timing2};
            `CANBT_ADDR_STATUS: reg_rdata <= {seg_cnt[3:0], seg_state, sync_done, sampled_bit};
            default: reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

endmodule

// file: rtl/canbt_defines.vh
/*
 Constants shared by the CAN bit timing block: register offsets, field
 positions, reset values, segment state codes and fixed timing figures.
 Assumes inclusion by bare name from the bit timer source, its only user.
*/
`ifndef CANBT_DEFINES_VH
`define CANBT_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CANBT_ADDR_TIMING0 3'h0
`define CANBT_ADDR_TIMING1 3'h1
`define CANBT_ADDR_TIMING2 3'h2
`define CANBT_ADDR_STATUS 3'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CANBT_JUMP_MSB 7
`define CANBT_JUMP_LSB 6
`define CANBT_PRESC_MSB 5
`define CANBT_PRESC_LSB 0
`define CANBT_PH2SRC_BIT 7
`define CANBT_TRIPLE_BIT 6
`define CANBT_PH1_MSB 5
`define CANBT_PH1_LSB 3
`define CANBT_PROP_MSB 2
`define CANBT_PROP_LSB 0
`define CANBT_PH2_MSB 2
`define CANBT_PH2_LSB 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CANBT_RST_TIMING0 8'h00
`define CANBT_RST_TIMING1 8'h00
`define CANBT_RST_TIMING2 3'h0

// ----------------------------------------
// Segment states and timing figures
// ----------------------------------------
`define CANBT_ST_SYNC 2'h0
`define CANBT_ST_PROP 2'h1
`define CANBT_ST_PH1 2'h2
`define CANBT_ST_PH2 2'h3
`define CANBT_SYNC_TQ 5'h01
`define CANBT_IPT_TQ 2'h2
`define CANBT_IPT_TQ_LEN 5'h02

`endif

// file: rtl/canbt_quantum_prescaler.v
/*
 Time quantum prescaler: one half-quantum enable every (field+1) clocks
 and a quantum enable on every second half tick.
 Assumes a single clock; restart realigns both enables to a new bit.
*/
`timescale 1ns/1ps
module canbt_quantum_prescaler #(
   parameter PRESC_W = 6
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Control
   input wire [PRESC_W-1:0] quantum_prescaler,
   input wire restart,
   // Enables
   output wire half_tick,
   output wire tq_tick
);

   reg [PRESC_W-1:0] div_cnt;
   reg half_phase;

   // Quantum is two half quanta, so the field value 0 gives two clocks
   // At or above the field, so a field lowered mid-count never waits out a wrap
   assign half_tick = (div_cnt >= quantum_prescaler) && !restart;
   assign tq_tick = half_tick && half_phase;

   // ----------------------------------------
   // Divider
   // ----------------------------------------
   // Restart clears both counters so the edge opens a fresh quantum
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_cnt <= {PRESC_W{1'b0}};
         half_phase <= 1'b0;
      end
      else if (restart)
      begin
         div_cnt <= {PRESC_W{1'b0}};
         half_phase <= 1'b0;
      end
      else if (half_tick)
      begin
         div_cnt <= {PRESC_W{1'b0}};
         half_phase <= ~half_phase;
      end
      else
      begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

endmodule

// file: rtl/canbt_sample_voter.v
/*
 Receive line sampler: keeps the two most recent half-quantum samples and
 forms the bit value, single or majority of three.
 Assumes the receive input is already synchronous to sys_clk.
*/
`timescale 1ns/1ps
module canbt_sample_voter (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Sampling
   input wire half_tick,
   input wire rx_level,
   input wire triple_sample_select,
   // Result
   output wire voted_bit
);

   reg [1:0] history;

   // Two earlier samples at half-quantum spacing, recessive after reset
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         history <= 2'h3;
      else if (half_tick)
         history <= {history[0], rx_level};
   end

   // Majority only when selected, otherwise the line as it is now
   assign voted_bit = triple_sample_select ?
      ((rx_level & history[0]) | (rx_level & history[1]) | (history[0] & history[1])) :
      rx_level;

endmodule

// file: tb/canbt_bit_timer_props.sv
/*
 Checker for the bit timer: strobe shapes, spacing, edge use.
 Assumes it is bound to canbt_bit_timer and sees only its ports.
*/
`timescale 1ns/1ps
module canbt_bit_timer_props #(
   parameter PRESC_W = 6,
   parameter ADDR_W = 3,
   parameter LEN_W = 5
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Register port
   input wire [ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_rdata,
   // Mode and status
   input wire config_mode,
   input wire bus_idle,
   input wire transmitting,
   // Bus line and results
   input wire can_receive_input,
   input wire bit_value,
   input wire bit_strobe,
   input wire sample_strobe,
   input wire sync_event
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence s_rise;
      !can_receive_input ##1 can_receive_input;
   endsequence
   // Processing delay is two quanta, at least two clocks each
   sequence s_resolve;
      ##[4:256] bit_strobe;
   endsequence

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_bit_pulse;
      bit_strobe |=> !bit_strobe;
   endproperty
   a_bit_pulse: assert property (p_bit_pulse) else $error("bit strobe longer than one cycle");
   property p_resolve;
      sample_strobe |-> s_resolve;
   endproperty
   a_resolve: assert property (p_resolve) else $error("no resolved bit after sample");
   property p_sample_gap;
      sample_strobe |=> !sample_strobe [*5];
   endproperty
   a_sample_gap: assert property (p_sample_gap) else $error("samples too close");
   property p_sync_gap;
      sync_event |=> !sync_event [*8];
   endproperty
   a_sync_gap: assert property (p_sync_gap) else $error("two syncs in one bit");
   property p_sync_on_fall;
      sync_event |-> $past(can_receive_input, 2) && !$past(can_receive_input);
   endproperty
   a_sync_on_fall: assert property (p_sync_on_fall) else $error("sync without falling edge");
   property p_rise_no_sync;
      s_rise |=> !sync_event;
   endproperty
   a_rise_no_sync: assert property (p_rise_no_sync) else $error("sync on rising edge");
   property p_value_hold;
      $changed(bit_value) |-> bit_strobe;
   endproperty
   a_value_hold: assert property (p_value_hold) else $error("bit value moved without strobe");
   // Only a hard sync is sure to restart the bit; an adjust may sit near the sample
   property p_sync_before_sample;
      sync_event && $past(bus_idle) |-> !sample_strobe [*5];
   endproperty
   a_sync_before_sample: assert property (p_sync_before_sample) else $error("sample too soon after sync");
   // Register port drives zero except in the cycle after a read strobe
   property p_rdata_idle;
      !$past(reg_read) |-> (reg_rdata == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
endmodule

bind canbt_bit_timer canbt_bit_timer_props #(.PRESC_W(PRESC_W), .ADDR_W(ADDR_W), .LEN_W(LEN_W))
   canbt_bit_timer_props_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .config_mode(config_mode), .bus_idle(bus_idle), .transmitting(transmitting),
   .can_receive_input(can_receive_input), .bit_value(bit_value), .bit_strobe(bit_strobe),
   .sample_strobe(sample_strobe), .sync_event(sync_event));

// file: tb/canbt_bus_model.sv
/*
 Bus model: the receive line as the transceiver hands it to the node.
 Assumes the bench calls drive right after it wants a new level.
*/
`timescale 1ns/1ps
module canbt_bus_model (
   // Clock
   input wire sys_clk,
   // Line, 1 recessive
   output reg can_receive_input
);
   // Idle bus rests recessive through the termination
   initial can_receive_input = 1'b1;

   // New level just after a rising edge
   task drive(input logic level);
      @(posedge sys_clk);
      can_receive_input <= level;
   endtask
endmodule

// file: tb/test_can_bit_timing_sync.sv
/*
 Bench for the bit timer: registers, segment timing, voting, resync.
 Assumes the bus model drives the line and the checker is bound.
*/
`timescale 1ns/1ps
module test_can_bit_timing_sync;
   logic sys_clk;
   logic reset_n;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic config_mode;
   logic bus_idle;
   logic transmitting;
   wire [7:0] reg_rdata;
   wire can_receive_input;
   wire bit_value;
   wire bit_strobe;
   wire sample_strobe;
   wire sync_event;
   integer failures;
   integer tests_run;
   integer n;

   canbt_bit_timer canbt_bit_timer_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .config_mode(config_mode), .bus_idle(bus_idle), .transmitting(transmitting),
      .can_receive_input(can_receive_input), .bit_value(bit_value), .bit_strobe(bit_strobe),
      .sample_strobe(sample_strobe), .sync_event(sync_event));
   canbt_bus_model canbt_bus_model_i (.sys_clk(sys_clk), .can_receive_input(can_receive_input));

   // ----------------------------------------
   // Clock and shared tasks
   // ----------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task close_out;
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task reg_rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask

   // Cycles until a strobe, bounded so a dead timer cannot hang
   task count_to(input integer which, output integer cnt);
      logic hit;
      cnt = 0;
      hit = 1'b0;
      while (hit !== 1'b1 && cnt < 400)
      begin
         @(posedge sys_clk);
         #1 cnt = cnt + 1;
         hit = (which == 0) ? sync_event : (which == 1) ? sample_strobe : bit_strobe;
      end
   endtask

   // Recessive idle long enough for the last sampled bit to be recessive
   task idle_wait;
      canbt_bus_model_i.drive(1'b1);
      bus_idle <= 1'b1;
      transmitting <= 1'b0;
      repeat (120) @(posedge sys_clk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Hard sync, then one dominant bit: sample, resolve, next sample
   task frame(input logic [5:0] presc, input logic [7:0] t1, input logic [7:0] t2, input integer ph2);
      integer tq;
      tq = 2 * (presc + 1);
      reg_wr(3'h0, {2'b00, presc});
      reg_wr(3'h1, t1);
      reg_wr(3'h2, t2);
      idle_wait;
      canbt_bus_model_i.drive(1'b0);
      count_to(0, n);
      check(n, 1);
      count_to(1, n);
      check(n, tq * (3 + t1[2:0] + t1[5:3]));
      count_to(2, n);
      check(n, 2 * tq);
      check(bit_value, 1'b0);
      count_to(1, n);
      check(n, tq * (ph2 + 1 + t1[2:0] + t1[5:3]));
   endtask

   // One recessive level only at the sample point itself
   task vote(input logic triple);
      reg_wr(3'h0, 8'h00);
      reg_wr(3'h1, {1'b0, triple, 6'h00});
      idle_wait;
      canbt_bus_model_i.drive(1'b0);
      repeat (5) @(posedge sys_clk);
      canbt_bus_model_i.drive(1'b1);
      canbt_bus_model_i.drive(1'b0);
      count_to(2, n);
      check(n, 4);
      check(bit_value, !triple);
   endtask

   // Dominant bit, recessive bit, then an edge: gap 32 puts it three quanta
   // into the bit, gap 40 one quantum into phase two
   task adjust(input logic [1:0] jf, input logic tx, input integer gap, input integer exp);
      reg_wr(3'h0, {jf, 6'h00});
      reg_wr(3'h1, 8'h18);
      idle_wait;
      canbt_bus_model_i.drive(1'b0);
      @(posedge sys_clk);
      bus_idle <= 1'b0;
      repeat (12) @(posedge sys_clk);
      canbt_bus_model_i.drive(1'b1);
      repeat (gap) @(posedge sys_clk);
      canbt_bus_model_i.drive(1'b0);
      transmitting <= tx;
      count_to(1, n);
      check(n, exp);
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      failures = 0;
      tests_run = 0;
      reset_n = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      config_mode = 1'b0;
      bus_idle = 1'b1;
      transmitting = 1'b0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      reg_rd(3'h0, 8'h00);
      reg_rd(3'h1, 8'h00);
      reg_rd(3'h2, 8'h00);
      reg_rd(3'h5, 8'h00);
      reg_wr(3'h0, 8'h55);
      reg_rd(3'h0, 8'h00);
      config_mode <= 1'b1;
      reg_wr(3'h0, 8'h55);
      reg_rd(3'h0, 8'h55);
      reg_wr(3'h2, 8'h05);
      reg_rd(3'h2, 8'h05);
      reg_wr(3'h6, 8'h3c);
      reg_rd(3'h6, 8'h00);
      frame(6'h00, 8'h00, 8'h00, 2);
      frame(6'h01, 8'h1a, 8'h07, 4);
      frame(6'h00, 8'hbf, 8'h05, 6);
      frame(6'h00, 8'h80, 8'h00, 2);
      vote(1'b0);
      vote(1'b1);
      adjust(2'h0, 1'b0, 32, 8);
      adjust(2'h1, 1'b0, 32, 10);
      adjust(2'h2, 1'b0, 32, 13);
      adjust(2'h3, 1'b0, 32, 13);
      adjust(2'h0, 1'b1, 32, 6);
      adjust(2'h0, 1'b0, 40, 16);
      adjust(2'h2, 1'b0, 40, 13);
      adjust(2'h0, 1'b1, 40, 16);
      close_out;
   end

   // Whole run needs well under 6000 cycles
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      failures = failures + 1;
      close_out;
   end
endmodule
